// ---- hdl/ucc_pkg.sv ----
// Purpose: shared constants and types for the configuration upset crc checker
// Assumes: pclk at 25 MHz, APB register access, 32-bit data
// Notes: offsets are byte addresses on the APB bus
package ucc_pkg;
    localparam int unsigned PCLK_KHZ = 25000;
    localparam int unsigned MASTER_CONFIG_CLK_DEFAULT_KHZ = 2500;
    localparam int unsigned MASTER_CONFIG_CLK_MAX_KHZ = 66000;
    localparam int unsigned FLASH_CHECK_KHZ = 3100;
    // half periods of the master configuration clock, in pclk cycles
    localparam logic [7:0] MC_HALF_DEFAULT = 8'(PCLK_KHZ / (2 * MASTER_CONFIG_CLK_DEFAULT_KHZ));
    localparam logic [7:0] MC_HALF_FLASH = 8'(PCLK_KHZ / (2 * FLASH_CHECK_KHZ));
    localparam logic [7:0] MC_HALF_MIN = ((PCLK_KHZ / (2 * MASTER_CONFIG_CLK_MAX_KHZ)) > 0) ?
        8'(PCLK_KHZ / (2 * MASTER_CONFIG_CLK_MAX_KHZ)) : 8'h01;
    localparam logic [2:0] DIV_CODE_DEFAULT = 3'h0;
    localparam logic [2:0] DIV_CODE_MAX = 3'h5;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned CFG_WORDS = 64;
    localparam int unsigned CFG_AW = 6;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned BIT_W = 5;
    localparam logic [CFG_AW-1:0] CFG_LAST = 6'h3F;
    localparam logic [BIT_W-1:0] BIT_LAST = 5'h1F;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_EXPECTED = 12'h008;
    localparam logic [11:0] REG_CALC = 12'h00C;
    localparam logic [11:0] REG_RECONFIG = 12'h010;
    localparam logic [11:0] REG_RAMMASK0 = 12'h014;
    localparam logic [11:0] REG_RAMMASK1 = 12'h018;
    localparam logic [11:0] CFG_BASE = 12'h100;
    localparam logic [11:0] CFG_TOP = 12'h1FC;
    localparam int unsigned CTRL_SINGLE_BIT = 0;
    localparam int unsigned CTRL_FLASH_BIT = 1;
    localparam int unsigned CTRL_DIV_LSB = 4;
    localparam int unsigned CTRL_MCH_LSB = 8;
    localparam logic [31:0] CTRL_RESET = {16'h0000, MC_HALF_DEFAULT, 1'b0, DIV_CODE_DEFAULT,
        4'h0};
    localparam int unsigned ST_RUN = 0;
    localparam int unsigned ST_FIN = 1;
    localparam int unsigned ST_UPS = 2;
    localparam int unsigned ST_ARM = 3;
    localparam int unsigned ST_VALID = 4;
    localparam int unsigned ST_PASS = 5;
    localparam int unsigned RECONF_BIT = 0;
    typedef enum logic [2:0] {
        CHK_IDLE,
        CHK_FETCH,
        CHK_LOAD,
        CHK_SHIFT,
        CHK_COMPARE
    } ucc_chk_t;
endpackage : ucc_pkg

// ---- hdl/ucc_cfg_mem.sv ----
// Purpose: configuration memory image that the checker reads back
// Assumes: one write port from the bus, one read port for the checker
// Notes: read data comes out of a register one pclk after rd_en
`timescale 1ns/1ps
`default_nettype none
module ucc_cfg_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [5:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic rd_en,
    input wire logic [5:0] rd_addr,
    output logic [31:0] rd_data
);
    typedef struct packed {
        logic [ucc_pkg::CFG_WORDS-1:0][ucc_pkg::WORD_W-1:0] mem;
        logic [31:0] rd_data;
    } ucc_mem_t;
    ucc_mem_t q;
    ucc_mem_t next_q;
    always_comb begin
        next_q = q;
        if (wr_en) begin
            next_q.mem[wr_addr] = wr_data;
        end
        if (rd_en) begin
            next_q.rd_data = q.mem[rd_addr];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
    assign rd_data = q.rd_data;
endmodule : ucc_cfg_mem
`default_nettype wire

// ---- hdl/ucc_crc32.sv ----
// Purpose: serial crc over the configuration bit stream
// Assumes: one data bit per shift strobe, msb first
// Notes: clear has priority over shift
`timescale 1ns/1ps
`default_nettype none
module ucc_crc32 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic shift,
    input wire logic data_bit,
    output logic [31:0] crc
);
    typedef struct packed {
        logic [31:0] crc;
    } ucc_crc_t;
    ucc_crc_t q;
    ucc_crc_t next_q;
    always_comb begin
        next_q = q;
        if (clear) begin
            next_q.crc = ucc_pkg::CRC_INIT;
        end else if (shift) begin
            next_q.crc = {q.crc[30:0], 1'b0} ^
                ((q.crc[31] ^ data_bit) ? ucc_pkg::CRC_POLY : 32'h00000000);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.crc <= ucc_pkg::CRC_INIT;
        end else begin
            q <= next_q;
        end
    end
    assign crc = q.crc;
endmodule : ucc_crc32
`default_nettype wire

// ---- hdl/ucc_checker.sv ----
// Purpose: configuration upset crc checker with APB registers and user-logic pins
// Assumes: check_arm, check_go and inject_fault_n come from logic on pclk
// Notes: the check clock is made from pclk; state moves on its rising edges
// How it works
// - serial crc compared with 32-bit expected
// - ram-used words skipped from read and crc
// - upset sticks until disarm or reconfigure
// - check clock divisor 1,2,4,8,16 or 32
// - flash mode: fixed 3.1 MHz, divisor 1
// - master clock defaults 2.5 MHz, max 12.5 (pclk/2)
// - gated clock copies check clock while armed
// - arm is a level, enables gated clock
// - inject low sampled forces upset high
// - running rises next clock after go
// - finished cleared by go or disarm
// - completion updates upset, running low, finished
// - go held high gives continuous checks
// - single pass ignores arm, go, inject
// - check length is bits plus small overhead
`timescale 1ns/1ps
`default_nettype none
module ucc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic check_arm,
    input wire logic check_go,
    input wire logic inject_fault_n,
    output logic gated_check_clk,
    output logic check_running,
    output logic check_finished,
    output logic upset_flag
);
    typedef struct packed {
        ucc_pkg::ucc_chk_t st;
        logic [ucc_pkg::CFG_AW-1:0] word;
        logic [ucc_pkg::BIT_W-1:0] bitn;
        logic [31:0] shreg;
        logic [ucc_pkg::HALF_W-1:0] half_cnt;
        logic clk_lvl;
        logic gated;
        logic running;
        logic finished;
        logic upset;
        logic valid;
        logic pass_done;
        logic [31:0] ctrl;
        logic [31:0] expected;
        logic [31:0] calc;
        logic [63:0] ram_mask;
        logic [31:0] prdata;
        logic pslverr;
    } ucc_state_t;

    ucc_state_t q;
    ucc_state_t next_q;

    logic [31:0] mem_rd_data;
    logic [31:0] crc_value;
    logic mem_wr_en;
    logic mem_rd_en;
    logic crc_clear;
    logic crc_shift;
    logic reconfig;
    logic rise;
    logic single_pass;
    logic flash_mode;
    logic arm_eff;
    logic go_eff;
    logic inject_eff;
    logic [7:0] mc_half;
    logic [5:0] divisor;
    logic [ucc_pkg::HALF_W-1:0] half_len;
    logic wr_access;

    // divisor code to divide ratio; codes past the last legal one fall back to 1
    function automatic logic [5:0] div_decode(input logic [2:0] code);
        logic [5:0] r;
        r = 6'h01;
        if (code <= ucc_pkg::DIV_CODE_MAX) begin
            r = 6'h01 << code;
        end
        return r;
    endfunction : div_decode

    function automatic logic is_cfg(input logic [11:0] a);
        return (a >= ucc_pkg::CFG_BASE) && (a <= ucc_pkg::CFG_TOP) && (a[1:0] == 2'h0);
    endfunction : is_cfg

    function automatic logic is_mapped(input logic [11:0] a);
        logic hit;
        hit = is_cfg(a);
        case (a)
            ucc_pkg::REG_CTRL, ucc_pkg::REG_STATUS, ucc_pkg::REG_EXPECTED,
            ucc_pkg::REG_CALC, ucc_pkg::REG_RECONFIG, ucc_pkg::REG_RAMMASK0,
            ucc_pkg::REG_RAMMASK1: hit = 1'b1;
            default: hit = hit;
        endcase
        return hit;
    endfunction : is_mapped

    ucc_cfg_mem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(mem_wr_en),
        .wr_addr(paddr[7:2]),
        .wr_data(pwdata),
        .rd_en(mem_rd_en),
        .rd_addr(q.word),
        .rd_data(mem_rd_data)
    );

    ucc_crc32 u_crc (
        .pclk(pclk),
        .presetn(presetn),
        .clear(crc_clear),
        .shift(crc_shift),
        .data_bit(q.shreg[31]),
        .crc(crc_value)
    );

    // zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign mem_wr_en = wr_access && is_cfg(paddr);
    assign reconfig = wr_access && (paddr == ucc_pkg::REG_RECONFIG) &&
        pwdata[ucc_pkg::RECONF_BIT];

    assign single_pass = q.ctrl[ucc_pkg::CTRL_SINGLE_BIT];
    assign flash_mode = q.ctrl[ucc_pkg::CTRL_FLASH_BIT];
    // single pass has no user inputs: armed, started once, never injected
    assign arm_eff = single_pass ? 1'b1 : check_arm;
    assign go_eff = single_pass ? !q.pass_done : check_go;
    assign inject_eff = single_pass ? 1'b1 : inject_fault_n;

    // flash mode pins the clock and the divisor regardless of ctrl
    always_comb begin
        mc_half = q.ctrl[ucc_pkg::CTRL_MCH_LSB +: 8];
        if (mc_half < ucc_pkg::MC_HALF_MIN) begin
            mc_half = ucc_pkg::MC_HALF_MIN;
        end
        divisor = div_decode(q.ctrl[ucc_pkg::CTRL_DIV_LSB +: 3]);
        if (flash_mode) begin
            mc_half = ucc_pkg::MC_HALF_FLASH;
            divisor = 6'h01;
        end
        // widen before the product, an 8-bit product would wrap
        half_len = ucc_pkg::HALF_W'(mc_half) * ucc_pkg::HALF_W'(divisor);
    end

    // rising edge of the check clock is the only moment the checker steps
    assign rise = (q.half_cnt == '0) && !q.clk_lvl;

    assign mem_rd_en = rise && arm_eff && !reconfig && (q.st == ucc_pkg::CHK_FETCH) &&
        !q.ram_mask[q.word];
    assign crc_clear = rise && arm_eff && !reconfig && (q.st == ucc_pkg::CHK_IDLE) && go_eff;
    assign crc_shift = rise && arm_eff && !reconfig && (q.st == ucc_pkg::CHK_SHIFT);

    always_comb begin
        next_q = q;

        // check clock generator; keeps running so the phase is steady
        if (q.half_cnt == '0) begin
            next_q.half_cnt = half_len - 1'b1;
            next_q.clk_lvl = !q.clk_lvl;
        end else begin
            next_q.half_cnt = q.half_cnt - 1'b1;
        end
        next_q.gated = next_q.clk_lvl && arm_eff;

        // bus setup cycle registers read data so it is stable in the access cycle
        if (psel && !penable) begin
            next_q.pslverr = !is_mapped(paddr);
            next_q.prdata = 32'h00000000;
            case (paddr)
                ucc_pkg::REG_CTRL: next_q.prdata = q.ctrl;
                ucc_pkg::REG_STATUS: begin
                    next_q.prdata[ucc_pkg::ST_RUN] = q.running;
                    next_q.prdata[ucc_pkg::ST_FIN] = q.finished;
                    next_q.prdata[ucc_pkg::ST_UPS] = q.upset;
                    next_q.prdata[ucc_pkg::ST_ARM] = arm_eff;
                    next_q.prdata[ucc_pkg::ST_VALID] = q.valid;
                    next_q.prdata[ucc_pkg::ST_PASS] = q.pass_done;
                end
                ucc_pkg::REG_EXPECTED: next_q.prdata = q.expected;
                ucc_pkg::REG_CALC: next_q.prdata = q.calc;
                ucc_pkg::REG_RAMMASK0: next_q.prdata = q.ram_mask[31:0];
                ucc_pkg::REG_RAMMASK1: next_q.prdata = q.ram_mask[63:32];
                default: next_q.prdata = 32'h00000000;
            endcase
        end
        if (wr_access) begin
            case (paddr)
                ucc_pkg::REG_CTRL: next_q.ctrl = pwdata;
                ucc_pkg::REG_EXPECTED: next_q.expected = pwdata;
                ucc_pkg::REG_RAMMASK0: next_q.ram_mask[31:0] = pwdata;
                ucc_pkg::REG_RAMMASK1: next_q.ram_mask[63:32] = pwdata;
                default: next_q.ctrl = q.ctrl;
            endcase
        end

        if (reconfig) begin
            // reconfiguration restarts the check and clears every status flag, upset included
            next_q.st = ucc_pkg::CHK_IDLE;
            next_q.running = 1'b0;
            next_q.finished = 1'b0;
            next_q.upset = 1'b0;
            next_q.valid = 1'b0;
            next_q.pass_done = 1'b0;
        end else if (!arm_eff) begin
            next_q.st = ucc_pkg::CHK_IDLE;
            next_q.running = 1'b0;
            next_q.finished = 1'b0;
            next_q.upset = 1'b0;
        end else if (rise) begin
            // inputs are taken as they stand at the edge, no synchroniser here
            if (!inject_eff) begin
                next_q.upset = 1'b1;
            end
            case (q.st)
                ucc_pkg::CHK_IDLE: begin
                    if (go_eff) begin
                        next_q.running = 1'b1;
                        next_q.finished = 1'b0;
                        next_q.word = '0;
                        next_q.st = ucc_pkg::CHK_FETCH;
                    end
                end
                ucc_pkg::CHK_FETCH: begin
                    // words that hold user ram are neither read nor hashed
                    if (q.ram_mask[q.word]) begin
                        if (q.word == ucc_pkg::CFG_LAST) begin
                            next_q.st = ucc_pkg::CHK_COMPARE;
                        end else begin
                            next_q.word = q.word + 1'b1;
                        end
                    end else begin
                        next_q.st = ucc_pkg::CHK_LOAD;
                    end
                end
                ucc_pkg::CHK_LOAD: begin
                    next_q.shreg = mem_rd_data;
                    next_q.bitn = '0;
                    next_q.st = ucc_pkg::CHK_SHIFT;
                end
                ucc_pkg::CHK_SHIFT: begin
                    // one configuration bit per check clock, msb first
                    next_q.shreg = {q.shreg[30:0], 1'b0};
                    next_q.bitn = q.bitn + 1'b1;
                    if (q.bitn == ucc_pkg::BIT_LAST) begin
                        if (q.word == ucc_pkg::CFG_LAST) begin
                            next_q.st = ucc_pkg::CHK_COMPARE;
                        end else begin
                            next_q.word = q.word + 1'b1;
                            next_q.st = ucc_pkg::CHK_FETCH;
                        end
                    end
                end
                ucc_pkg::CHK_COMPARE: begin
                    next_q.calc = crc_value;
                    next_q.valid = 1'b1;
                    if (crc_value != q.expected) begin
                        next_q.upset = 1'b1;
                    end
                    next_q.running = 1'b0;
                    next_q.finished = 1'b1;
                    next_q.pass_done = 1'b1;
                    // idle sees go again on the next edge, so a held go loops
                    next_q.st = ucc_pkg::CHK_IDLE;
                end
                default: next_q.st = ucc_pkg::CHK_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.st <= ucc_pkg::CHK_IDLE;
            q.ctrl <= ucc_pkg::CTRL_RESET;
        end else begin
            q <= next_q;
        end
    end

    // status outputs change together with the gated clock rising edge, except on disarm or reconfigure
    assign gated_check_clk = q.gated;
    assign check_running = q.running;
    assign check_finished = q.finished;
    assign upset_flag = q.upset;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
endmodule : ucc_checker
`default_nettype wire

// ---- dv/ucc_checker_assertions.sv ----
// Purpose: pin-level assertions for the crc checker
// Assumes: one pclk domain, presetn active low
// Notes: outputs move on gated clock rises, save disarm and reconfigure
`timescale 1ns/1ps
`default_nettype none
module ucc_checker_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic check_arm,
    input wire logic check_go,
    input wire logic inject_fault_n,
    input wire logic gated_check_clk,
    input wire logic check_running,
    input wire logic check_finished,
    input wire logic upset_flag
);
    logic reconf_wr;
    // a reconfigure write may clear outputs off the check edge, so it is excused
    assign reconf_wr = psel && penable && pwrite && pwdata[0] && paddr == ucc_pkg::REG_RECONFIG;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence check_edge;
        $rose(gated_check_clk);
    endsequence
    sequence go_at_idle;
        check_go && check_arm && check_finished ##1 check_edge;
    endsequence
    sequence inject_at_edge;
        !inject_fault_n && check_arm ##1 check_edge;
    endsequence
    AST_RUN_ON_GO: assert property (
        $rose(check_running) |-> $past(check_go) ##0 check_edge)
        else $error("running rose without go on a check edge");
    AST_RUN_STEADY: assert property (
        $changed(check_running) && $past(check_arm) |-> check_edge)
        else $error("running moved off a check edge");
    AST_FIN_AT_END: assert property (
        $rose(check_finished) |-> $fell(check_running) ##0 check_edge)
        else $error("finished rose without running falling on a check edge");
    AST_UPSET_ON_EDGE: assert property ($rose(upset_flag) |-> check_edge)
        else $error("upset rose off a check edge");
    AST_UPSET_STICKY: assert property (
        upset_flag && check_arm && !reconf_wr |=> upset_flag)
        else $error("upset dropped while armed");
    AST_DISARM_CLEARS: assert property (
        !check_arm |=> !check_running && !check_finished && !upset_flag)
        else $error("outputs not cleared while disarmed");
    AST_GATED_QUIET: assert property (!check_arm [*2] |-> !gated_check_clk)
        else $error("gated clock high while disarmed");
    AST_GO_CLEARS_FIN: assert property (
        go_at_idle |-> check_running && !check_finished)
        else $error("go at idle did not restart");
    AST_INJECT_SETS: assert property (inject_at_edge |-> upset_flag)
        else $error("inject did not raise upset");
    AST_APB_READY: assert property (psel && penable |-> pready)
        else $error("pready low in access cycle");
    AST_UNMAPPED_ERR: assert property (psel && penable && paddr == 12'h020 |-> pslverr)
        else $error("no slave error on unmapped address");
endmodule : ucc_checker_assertions
bind ucc_checker ucc_checker_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .check_arm(check_arm), .check_go(check_go), .inject_fault_n(inject_fault_n),
    .gated_check_clk(gated_check_clk), .check_running(check_running),
    .check_finished(check_finished), .upset_flag(upset_flag)
);
`default_nettype wire

// ---- dv/ucc_user_model.sv ----
// Purpose: user logic model driving arm, go and inject
// Assumes: runs on pclk, the checker's own domain
// Notes: go is stretched so a short request still spans a check period
`timescale 1ns/1ps
`default_nettype none
module ucc_user_model #(
    parameter int GO_HOLD = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic arm_req,
    input wire logic go_req,
    input wire logic fault_req,
    input wire logic upset_flag,
    output logic check_arm,
    output logic check_go,
    output logic inject_fault_n,
    output logic [7:0] upsets_logged
);
    logic [7:0] hold;
    logic upset_seen;
    // requests are registered here since the checker does no synchronising
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            check_arm <= 1'b0;
            check_go <= 1'b0;
            inject_fault_n <= 1'b1;
            hold <= 8'h00;
            upset_seen <= 1'b0;
            upsets_logged <= 8'h00;
        end else begin
            check_arm <= arm_req;
            inject_fault_n <= !fault_req;
            hold <= go_req ? 8'(GO_HOLD) : hold - ((hold != 8'h00) ? 8'h01 : 8'h00);
            check_go <= go_req || (hold != 8'h00);
            upset_seen <= upset_flag;
            if (upset_flag && !upset_seen) begin
                upsets_logged <= upsets_logged + 8'h01;
            end
        end
    end
endmodule : ucc_user_model
`default_nettype wire

// ---- dv/ucc_testbench.sv ----
// Purpose: self-checking bench for the crc checker
// Assumes: mc_half 1 during checks, so one check period is 2 pclk
// Notes: expected crc is worked out here, msb first, unmasked words only
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed { logic [31:0] ctrl; logic [15:0] period; } ucc_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat, crc;
    logic pready, pslverr, err, gated_check_clk, check_running, check_finished, upset_flag;
    logic check_arm, check_go, inject_fault_n;
    logic arm_req = 1'b0, go_req = 1'b0, fault_req = 1'b0;
    logic [7:0] upsets_logged;
    int num_errors = 0, n_tests = 0, a, b;
    ucc_row_t rows [9] = '{'{32'h0000_0500, 16'h000A}, '{32'h0000_0100, 16'h0002},
        '{32'h0000_0110, 16'h0004}, '{32'h0000_0120, 16'h0008}, '{32'h0000_0130, 16'h0010},
        '{32'h0000_0140, 16'h0020}, '{32'h0000_0150, 16'h0040}, '{32'h0000_0160, 16'h0002},
        '{32'h0000_0532, 16'h0008}};
    ucc_checker u_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .check_arm(check_arm), .check_go(check_go), .inject_fault_n(inject_fault_n),
        .gated_check_clk(gated_check_clk), .check_running(check_running),
        .check_finished(check_finished), .upset_flag(upset_flag));
    ucc_user_model u_user (
        .pclk(pclk), .presetn(presetn), .arm_req(arm_req), .go_req(go_req),
        .fault_req(fault_req), .upset_flag(upset_flag), .check_arm(check_arm),
        .check_go(check_go), .inject_fault_n(inject_fault_n), .upsets_logged(upsets_logged));
    initial begin
        forever #20 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) chk("pready", 32'h1, 32'h0);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic sig(input int s);
        case (s)
            0: return check_running;
            1: return check_finished;
            2: return upset_flag;
            default: return gated_check_clk;
        endcase
    endfunction : sig
    // waits are bounded so a stuck output is reported rather than hanging
    task automatic wait_sig(input int s, input logic v, output int c);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (sig(s) !== v && c < 2000);
        if (c >= 2000) chk("wait", 32'h0, 32'h1);
    endtask : wait_sig
    function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? ucc_pkg::CRC_POLY : 32'h0);
        end
        return c;
    endfunction : crc_word
    function automatic logic [31:0] outs();
        return {29'h0, upset_flag, check_finished, check_running};
    endfunction : outs
    task automatic go_once();
        go_req <= 1'b1;
        wait_sig(0, 1'b1, a);
        go_req <= 1'b0;
        wait_sig(1, 1'b1, a);
    endtask : go_once
    initial begin
        #(40 * 30000);
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset outputs", 32'h0, outs() | {31'h0, gated_check_clk});
        apb(1'b0, ucc_pkg::REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h0000_0500, rdat);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        arm_req <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, ucc_pkg::REG_CTRL, rows[i].ctrl);
            repeat (2) begin
                wait_sig(3, 1'b0, a);
                wait_sig(3, 1'b1, a);
            end
            wait_sig(3, 1'b0, a);
            wait_sig(3, 1'b1, b);
            chk("gated period", 32'(rows[i].period), 32'(a + b));
        end
        arm_req <= 1'b0;
        repeat (3) @(posedge pclk);
        a = 0;
        repeat (40) begin
            @(posedge pclk);
            a += int'(gated_check_clk !== 1'b0);
        end
        chk("gated quiet", 32'h0, 32'(a));
        apb(1'b1, ucc_pkg::REG_CTRL, 32'h0000_0100);
        apb(1'b1, ucc_pkg::REG_RAMMASK0, 32'hFFFF_FFFA);
        apb(1'b1, ucc_pkg::REG_RAMMASK1, 32'hFFFF_FFFF);
        apb(1'b1, ucc_pkg::CFG_BASE, 32'h1234_5678);
        apb(1'b1, ucc_pkg::CFG_BASE + 12'h004, 32'hDEAD_BEEF);
        apb(1'b1, ucc_pkg::CFG_BASE + 12'h008, 32'hA5C3_0F69);
        crc = crc_word(crc_word(ucc_pkg::CRC_INIT, 32'h1234_5678), 32'hA5C3_0F69);
        apb(1'b1, ucc_pkg::REG_EXPECTED, crc);
        arm_req <= 1'b1;
        go_once();
        chk("check length", 32'h0000_0106, 32'(a));
        chk("clean end", 32'h2, outs());
        apb(1'b0, ucc_pkg::REG_CALC, 32'h0);
        chk("calculated crc", crc, rdat);
        // a masked word changes, checks run back to back and must stay clean
        apb(1'b1, ucc_pkg::CFG_BASE + 12'h004, 32'h0BAD_F00D);
        go_req <= 1'b1;
        wait_sig(1, 1'b0, a);
        chk("restart", 32'h1, outs());
        wait_sig(1, 1'b1, a);
        chk("masked word ignored", 32'h2, outs());
        wait_sig(1, 1'b0, a);
        go_req <= 1'b0;
        chk("continuous", 32'h1, outs());
        wait_sig(1, 1'b1, a);
        apb(1'b1, ucc_pkg::CFG_BASE + 12'h008, 32'hA5C3_0F68);
        go_once();
        chk("mismatch", 32'h6, outs());
        apb(1'b0, ucc_pkg::REG_CALC, 32'h0);
        crc = crc_word(crc_word(ucc_pkg::CRC_INIT, 32'h1234_5678), 32'hA5C3_0F68);
        chk("bad crc", crc, rdat);
        repeat (20) @(posedge pclk);
        chk("upset sticks", 32'h1, {31'h0, upset_flag});
        chk("upsets logged", 32'h1, {24'h0, upsets_logged});
        arm_req <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("disarm clears", 32'h0, outs());
        arm_req <= 1'b1;
        fault_req <= 1'b1;
        wait_sig(2, 1'b1, a);
        fault_req <= 1'b0;
        chk("inject", 32'h4, outs());
        apb(1'b1, ucc_pkg::REG_RECONFIG, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk("reconfigure clears", 32'h0, outs());
        go_req <= 1'b1;
        wait_sig(0, 1'b1, a);
        go_req <= 1'b0;
        repeat (30) @(posedge pclk);
        arm_req <= 1'b0;
        repeat (3) @(posedge pclk);
        arm_req <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("abandoned check", 32'h0, outs());
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
